// file: core/pue_uncorr_error_log.sv
// Summary of operation
// - Status bits stay set; writing one clears a bit, writing zero keeps it.
// - Status bits survive ordinary reset; only power-on reset zeroes them.
// - End-to-end CRC bit 19 and bits 31:21 always read zero, ignore writes.
// - Unsupported request sets bit 20 and logs the header if first error.
// - Only the first error of bits 20 and 18:15 loads the header log; timeout and flow control errors (bits 14, 13) never load it.
// - Malformed received packet sets bit 18.
// - Overflow of posted, non-posted or completion receive queue sets bit 17.
// - Completion matching no outstanding request sets bit 16.
// - Legal request violating this device's programming model sets bit 15.
// - Uncompleted request times out between 50 us and 16 ms, setting bit 14.
// - Finite credit update for a class advertised infinite sets bit 13.
module pue_uncorr_error_log #(
  parameter int P_CPL_TIMEOUT_CYC = pue_pkg::CPL_TO_DEF_CYC
) (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_resetn,
  input  wire logic                      i_hot_reset,
  input  wire logic                      i_cfg_wr,
  input  wire logic                      i_cfg_rd,
  input  wire logic [11:0]               i_cfg_addr,
  input  wire logic [31:0]               i_cfg_wdata,
  input  wire logic                      i_unsup_req,
  input  wire logic                      i_malformed,
  input  wire logic                      i_ovf_posted,
  input  wire logic                      i_ovf_non_posted,
  input  wire logic                      i_ovf_completion,
  input  wire logic                      i_unexp_cpl,
  input  wire logic                      i_cpl_abort,
  input  wire logic                      i_req_issue,
  input  wire logic [pue_pkg::TAG_W-1:0] i_req_tag,
  input  wire logic                      i_cpl_rcv,
  input  wire logic [pue_pkg::TAG_W-1:0] i_cpl_tag,
  input  wire logic                      i_fc_init_vld,
  input  wire logic                      i_fc_upd_vld,
  input  wire logic [1:0]                i_fc_class,
  input  wire logic [7:0]                i_fc_hdr_cred,
  input  wire logic [11:0]               i_fc_data_cred,
  output logic [31:0]                    o_cfg_rdata,
  output logic                           o_cfg_rvalid,
  output logic [31:0]                    o_uncorr_status,
  output logic                           o_hdr_log_load,
  output logic                           o_first_err_logged
);

  localparam logic [pue_pkg::CNT_W-1:0] TO_LAST = pue_pkg::CNT_W'(P_CPL_TIMEOUT_CYC - 1);

  function automatic logic is_status_addr(input logic [11:0] addr);
    is_status_addr = (addr == pue_pkg::STATUS_OFFSET);
  endfunction : is_status_addr

  logic [31:0]               status_q;
  logic [31:0]               status_d;
  logic                      first_q;
  logic                      first_d;
  logic                      load_q;
  logic                      load_d;
  logic [pue_pkg::SLOTS-1:0] slot_vld_q;
  logic [pue_pkg::SLOTS-1:0] slot_vld_d;
  logic [pue_pkg::CNT_W-1:0] slot_cnt_q [pue_pkg::SLOTS];
  logic [pue_pkg::CNT_W-1:0] slot_cnt_d [pue_pkg::SLOTS];
  logic [5:0]                fc_inf_q;
  logic [5:0]                fc_inf_d;
  logic [31:0]               rdata_q;
  logic [31:0]               rdata_d;
  logic                      rvalid_q;
  logic                      rvalid_d;
  logic                      cto_ev;
  logic                      stray_cpl;
  logic                      fcpe_ev;
  logic [31:0]               set_vec;
  logic [31:0]               clr_vec;
  logic                      hdr_ev;
  logic                      wr_status;

  assign wr_status = i_cfg_wr && is_status_addr(i_cfg_addr);

  // Outstanding request tracker; a completion in the expiry cycle wins over the timeout.
  always_comb begin
    slot_vld_d = slot_vld_q;
    slot_cnt_d = slot_cnt_q;
    cto_ev     = 1'b0;
    stray_cpl  = 1'b0;
    for (int i = 0; i < pue_pkg::SLOTS; i++) begin
      if (slot_vld_q[i]) begin
        if (i_cpl_rcv && (i_cpl_tag == pue_pkg::TAG_W'(i))) begin
          slot_vld_d[i] = 1'b0;
        end else if (slot_cnt_q[i] == TO_LAST) begin
          slot_vld_d[i] = 1'b0;
          cto_ev        = 1'b1;
        end else begin
          slot_cnt_d[i] = slot_cnt_q[i] + pue_pkg::CNT_W'(1);
        end
      end
    end
    if (i_cpl_rcv && !slot_vld_q[i_cpl_tag]) begin
      stray_cpl = 1'b1;
    end
    if (i_req_issue) begin
      slot_vld_d[i_req_tag] = 1'b1;
      slot_cnt_d[i_req_tag] = '0;
    end
    if (i_hot_reset) begin
      slot_vld_d = '0;
      for (int i = 0; i < pue_pkg::SLOTS; i++) begin
        slot_cnt_d[i] = '0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      slot_vld_q <= '0;
      for (int i = 0; i < pue_pkg::SLOTS; i++) begin
        slot_cnt_q[i] <= '0;
      end
    end else begin
      slot_vld_q <= slot_vld_d;
      slot_cnt_q <= slot_cnt_d;
    end
  end

  // Flow control credit tracking: remember which credits were advertised infinite.
  always_comb begin
    fc_inf_d = fc_inf_q;
    fcpe_ev  = 1'b0;
    if (i_fc_class != 2'h3) begin
      if (i_fc_init_vld) begin
        fc_inf_d[{i_fc_class, 1'b0}] = (i_fc_hdr_cred == 8'h00);
        fc_inf_d[{i_fc_class, 1'b1}] = (i_fc_data_cred == 12'h000);
      end else if (i_fc_upd_vld) begin
        fcpe_ev = (fc_inf_q[{i_fc_class, 1'b0}] && (i_fc_hdr_cred != 8'h00)) ||
                  (fc_inf_q[{i_fc_class, 1'b1}] && (i_fc_data_cred != 12'h000));
      end
    end
    if (i_hot_reset) begin
      fc_inf_d = '0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      fc_inf_q <= '0;
    end else begin
      fc_inf_q <= fc_inf_d;
    end
  end

  // Sticky status, first-error indication and header log load strobe.
  always_comb begin
    set_vec                           = '0;
    set_vec[pue_pkg::BIT_UNSUP_REQ]   = i_unsup_req;
    set_vec[pue_pkg::BIT_MALFORMED]   = i_malformed;
    set_vec[pue_pkg::BIT_RX_OVERFLOW] = i_ovf_posted | i_ovf_non_posted | i_ovf_completion;
    set_vec[pue_pkg::BIT_UNEXP_CPL]   = i_unexp_cpl | stray_cpl;
    set_vec[pue_pkg::BIT_CPL_ABORT]   = i_cpl_abort;
    set_vec[pue_pkg::BIT_CPL_TIMEOUT] = cto_ev;
    set_vec[pue_pkg::BIT_FC_PROTOCOL] = fcpe_ev;
    clr_vec  = wr_status ? i_cfg_wdata : 32'h0000_0000;
    // A set in the clearing cycle wins; unimplemented bits are forced to zero.
    status_d = ((status_q & ~clr_vec) | set_vec) & pue_pkg::STATUS_IMPL_MASK;
    hdr_ev   = |(set_vec & pue_pkg::HDR_LOG_MASK);
    load_d   = hdr_ev && !first_q;
    first_d  = (first_q || load_d) && (status_d != 32'h0000_0000);
  end

  // Only power-on reset reaches these flops; hot reset leaves them alone.
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      status_q <= pue_pkg::STATUS_RESET;
      first_q  <= 1'b0;
      load_q   <= 1'b0;
    end else begin
      status_q <= status_d;
      first_q  <= first_d;
      load_q   <= load_d;
    end
  end

  // Configuration read port; other offsets read as zero.
  always_comb begin
    rvalid_d = i_cfg_rd && !i_hot_reset;
    rdata_d  = 32'h0000_0000;
    if (i_cfg_rd && is_status_addr(i_cfg_addr)) begin
      rdata_d = status_q;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign o_cfg_rdata        = rdata_q;
  assign o_cfg_rvalid       = rvalid_q;
  assign o_uncorr_status    = status_q;
  assign o_hdr_log_load     = load_q;
  assign o_first_err_logged = first_q;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);

  sequence s_status_read;
    i_cfg_rd && !i_hot_reset && is_status_addr(i_cfg_addr);
  endsequence

  sequence s_ur_first;
    i_unsup_req && !first_q;
  endsequence

  property p_sticky_hold;
    status_q[pue_pkg::BIT_MALFORMED] && !(wr_status && i_cfg_wdata[pue_pkg::BIT_MALFORMED])
      |=> status_q[pue_pkg::BIT_MALFORMED];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold)
    else $error("status bit dropped without a write of one");

  property p_w1c_clear;
    wr_status && i_cfg_wdata[pue_pkg::BIT_UNSUP_REQ] && !i_unsup_req
      |=> !status_q[pue_pkg::BIT_UNSUP_REQ];
  endproperty
  a_w1c_clear: assert property (p_w1c_clear)
    else $error("write of one did not clear status bit");

  property p_hot_keep;
    i_hot_reset && !wr_status && (set_vec == 32'h0000_0000) |=> $stable(status_q);
  endproperty
  a_hot_keep: assert property (p_hot_keep)
    else $error("status changed across ordinary reset");

  property p_unimpl_zero;
    s_status_read |=> (o_cfg_rdata[pue_pkg::BIT_E2E_CRC] == 1'b0) && (o_cfg_rdata[31:21] == 11'h000) && o_cfg_rvalid;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented status bits read non-zero");

  property p_ur_logs;
    s_ur_first |=> status_q[pue_pkg::BIT_UNSUP_REQ] && o_hdr_log_load ##1 !o_hdr_log_load;
  endproperty
  a_ur_logs: assert property (p_ur_logs)
    else $error("first unsupported request did not log header");

  property p_no_reload;
    first_q |=> !o_hdr_log_load;
  endproperty
  a_no_reload: assert property (p_no_reload)
    else $error("header log reloaded after first error");

  property p_malformed_set;
    i_malformed |=> status_q[pue_pkg::BIT_MALFORMED];
  endproperty
  a_malformed_set: assert property (p_malformed_set)
    else $error("malformed packet not recorded");

  property p_overflow_set;
    i_ovf_posted || i_ovf_non_posted || i_ovf_completion |=> status_q[pue_pkg::BIT_RX_OVERFLOW];
  endproperty
  a_overflow_set: assert property (p_overflow_set)
    else $error("receive queue overflow not recorded");

  property p_stray_cpl;
    i_cpl_rcv && !slot_vld_q[i_cpl_tag] |=> status_q[pue_pkg::BIT_UNEXP_CPL];
  endproperty
  a_stray_cpl: assert property (p_stray_cpl)
    else $error("unexpected completion not recorded");

  property p_abort_set;
    i_cpl_abort && !first_q |=> status_q[pue_pkg::BIT_CPL_ABORT] && o_hdr_log_load && first_q;
  endproperty
  a_abort_set: assert property (p_abort_set)
    else $error("completer abort not recorded and logged");

  property p_timeout_fire;
    slot_vld_q[0] && (slot_cnt_q[0] == TO_LAST) && !(i_cpl_rcv && (i_cpl_tag == '0)) &&
      !(i_req_issue && (i_req_tag == '0))
      |=> status_q[pue_pkg::BIT_CPL_TIMEOUT] && !slot_vld_q[0];
  endproperty
  a_timeout_fire: assert property (p_timeout_fire)
    else $error("completion timeout did not fire on time");

  property p_timeout_window;
    cto_ev |-> (P_CPL_TIMEOUT_CYC >= pue_pkg::CPL_TO_MIN_CYC) && (P_CPL_TIMEOUT_CYC <= pue_pkg::CPL_TO_MAX_CYC);
  endproperty
  a_timeout_window: assert property (p_timeout_window)
    else $error("completion timeout outside allowed window");

  property p_fc_error;
    i_fc_upd_vld && !i_fc_init_vld && (i_fc_class == pue_pkg::FC_POSTED) && fc_inf_q[0] && (i_fc_hdr_cred != 8'h00)
      |=> status_q[pue_pkg::BIT_FC_PROTOCOL];
  endproperty
  a_fc_error: assert property (p_fc_error)
    else $error("finite update of infinite credit not recorded");

  property p_rearm;
    (status_q == 32'h0000_0000) |-> !first_q;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("first error indication held with status clear");

endmodule : pue_uncorr_error_log

// file: pkg/pue_pkg.sv
package pue_pkg;

  // Register map, reached at its configuration space byte offset.
  localparam logic [11:0] STATUS_OFFSET    = 12'h104;
  localparam logic [31:0] STATUS_RESET     = 32'h0000_0000;

  // Bit positions of the uncorrectable error status register.
  localparam int          BIT_UNSUP_REQ    = 20;
  localparam int          BIT_E2E_CRC      = 19;
  localparam int          BIT_MALFORMED    = 18;
  localparam int          BIT_RX_OVERFLOW  = 17;
  localparam int          BIT_UNEXP_CPL    = 16;
  localparam int          BIT_CPL_ABORT    = 15;
  localparam int          BIT_CPL_TIMEOUT  = 14;
  localparam int          BIT_FC_PROTOCOL  = 13;

  // Implemented bits, and those among them that load the header log.
  localparam logic [31:0] STATUS_IMPL_MASK = 32'h0017_E000;
  localparam logic [31:0] HDR_LOG_MASK     = 32'h0017_8000;

  // Completion timeout window.
  localparam int          CLK_PERIOD_NS    = 40;
  localparam int          CPL_TO_MIN_NS    = 50_000;
  localparam int          CPL_TO_MAX_NS    = 16_000_000;
  localparam int          CPL_TO_MIN_CYC   = (CPL_TO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CPL_TO_MAX_CYC   = CPL_TO_MAX_NS / CLK_PERIOD_NS;
  localparam int          CPL_TO_DEF_CYC   = 25_000;

  // Request tracker geometry.
  localparam int          TAG_W            = 2;
  localparam int          SLOTS            = 4;
  localparam int          CNT_W            = 19;

  // Flow control classes; a credit value of zero advertises infinite credit.
  localparam logic [1:0]  FC_POSTED        = 2'h0;
  localparam logic [1:0]  FC_NON_POSTED    = 2'h1;
  localparam logic [1:0]  FC_COMPLETION    = 2'h2;
  localparam int          FC_CLASSES       = 3;

endpackage : pue_pkg

// file: testbench/pue_link_partner.sv
// Answers the most recent request after P_LAT cycles unless told to drop it, and can send a stray completion.
module pue_link_partner #(
  parameter int P_LAT = 20
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_issue,
  input  wire logic       i_drop,
  input  wire logic       i_stray,
  input  wire logic [1:0] i_tag,
  output logic            o_cpl_rcv = 1'b0,
  output logic [1:0]      o_cpl_tag = 2'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       go_q  = 1'b0;
  logic [1:0] tag_q = 2'h0;
  int         lat_q = 0;
  int         cnt   = 0;
  always @(posedge i_clk_sys) begin
    go_q <= (i_issue && !i_drop) || i_stray;
    if ((i_issue && !i_drop) || i_stray) begin
      tag_q <= i_tag;
      lat_q <= i_stray ? 1 : P_LAT;
    end
  end
  // The idle tag keeps moving so a stale value never looks like a real answer.
  always @(negedge i_clk_sys) begin
    o_cpl_rcv <= 1'b0;
    o_cpl_tag <= o_cpl_tag + 2'h1;
    if (go_q) begin
      cnt <= lat_q;
    end else if (cnt == 1) begin
      o_cpl_rcv <= 1'b1;
      o_cpl_tag <= tag_q;
      cnt       <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : pue_link_partner

// file: testbench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          P_TO = 1250;
  localparam logic [31:0] ONES = 32'hFFFF_FFFF;
  logic        i_clk_sys = 1'b0;
  logic        i_resetn  = 1'b0;
  logic        hot = 1'b0, wr = 1'b0, rd = 1'b0, iss = 1'b0, drop = 1'b0, stray = 1'b0, fci = 1'b0, fcu = 1'b0;
  logic [11:0] addr = 12'h000, fcd = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, status, exp_s = 32'h0, seed = 32'h3;
  logic [6:0]  ev = 7'h00;
  logic [1:0]  tag = 2'h0, fcc = 2'h0, ctag;
  logic [7:0]  fch = 8'h00;
  logic        cpl, rvalid, load, first, exp_f = 1'b0;
  int          err_total = 0, samples_checked = 0, cyc = 0;
  logic [31:0] evb [7] = '{32'h0010_0000, 32'h0004_0000, 32'h0002_0000, 32'h0002_0000, 32'h0002_0000,
                           32'h0001_0000, 32'h0000_8000};

  always #20 i_clk_sys = ~i_clk_sys;

  pue_uncorr_error_log #(.P_CPL_TIMEOUT_CYC(P_TO)) dut (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_hot_reset(hot), .i_cfg_wr(wr), .i_cfg_rd(rd),
    .i_cfg_addr(addr), .i_cfg_wdata(wdata), .i_unsup_req(ev[0]), .i_malformed(ev[1]), .i_ovf_posted(ev[2]),
    .i_ovf_non_posted(ev[3]), .i_ovf_completion(ev[4]), .i_unexp_cpl(ev[5]), .i_cpl_abort(ev[6]),
    .i_req_issue(iss), .i_req_tag(tag), .i_cpl_rcv(cpl), .i_cpl_tag(ctag), .i_fc_init_vld(fci),
    .i_fc_upd_vld(fcu), .i_fc_class(fcc), .i_fc_hdr_cred(fch), .i_fc_data_cred(fcd), .o_cfg_rdata(rdata),
    .o_cfg_rvalid(rvalid), .o_uncorr_status(status), .o_hdr_log_load(load), .o_first_err_logged(first));

  pue_link_partner #(.P_LAT(20)) partner (
    .i_clk_sys(i_clk_sys), .i_issue(iss), .i_drop(drop), .i_stray(stray), .i_tag(tag),
    .o_cpl_rcv(cpl), .o_cpl_tag(ctag));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk

  task automatic end_of_test();
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  // One cycle: drive at the falling edge, predict, then check at the next falling edge.
  task automatic tick(input logic [6:0] e, input logic w, input logic [31:0] wd, input logic h,
                      input logic [31:0] xs);
    logic [31:0] r, set, old;
    logic        bad, ld;
    r = rnd();
    bad = r[3:0] == 4'h0;
    ev = e;
    wr = w;
    wdata = wd;
    hot = h;
    rd = r[4];
    addr = bad ? 12'h108 : pue_pkg::STATUS_OFFSET;
    set = xs;
    for (int k = 0; k < 7; k++) if (e[k]) set |= evb[k];
    old = exp_s;
    ld = ((set & pue_pkg::HDR_LOG_MASK) != 32'h0) && !exp_f;
    exp_s = (exp_s & ~((w && !bad) ? wd & pue_pkg::STATUS_IMPL_MASK : 32'h0)) | set;
    exp_f = ld || (exp_f && exp_s != 32'h0);
    @(negedge i_clk_sys);
    chk(status, exp_s);
    chk({31'h0, load}, {31'h0, ld});
    chk({31'h0, first}, {31'h0, exp_f});
    chk({31'h0, rvalid}, {31'h0, rd && !h});
    if (rd && !h) chk(rdata, bad ? 32'h0 : old);
  endtask : tick

  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    logic [31:0] r;
    repeat (8) @(negedge i_clk_sys);
    i_resetn = 1'b1;
    tick(7'h00, 1'b1, ONES, 1'b0, 32'h0);
    for (int k = 0; k < 7; k++) tick(7'h01 << k, 1'b0, 32'h0, 1'b0, 32'h0);
    tick(7'h00, 1'b1, 32'h0, 1'b0, 32'h0);
    tick(7'h00, 1'b1, 32'h0010_0000, 1'b0, 32'h0);
    tick(7'h00, 1'b0, 32'h0, 1'b1, 32'h0);
    tick(7'h02, 1'b1, ONES, 1'b0, 32'h0);
    tick(7'h00, 1'b1, ONES, 1'b0, 32'h0);
    tick(7'h40, 1'b0, 32'h0, 1'b0, 32'h0);
    repeat (200) begin
      r = rnd();
      tick(r[9:7] == 3'h0 ? r[6:0] : 7'h00, r[12:10] == 3'h0, rnd(), r[15:13] == 3'h0, 32'h0);
    end
    tick(7'h00, 1'b1, ONES, 1'b0, 32'h0);
    drop = 1'b1;
    iss = 1'b1;
    tag = 2'h0;
    tick(7'h00, 1'b0, 32'h0, 1'b0, 32'h0);
    iss = 1'b0;
    repeat (P_TO - 1) tick(7'h00, 1'b0, 32'h0, 1'b0, 32'h0);
    tick(7'h00, 1'b0, 32'h0, 1'b0, 32'h0000_4000);
    drop = 1'b0;
    iss = 1'b1;
    tag = 2'h2;
    tick(7'h00, 1'b1, ONES, 1'b0, 32'h0);
    iss = 1'b0;
    repeat (P_TO + 50) tick(7'h00, 1'b0, 32'h0, 1'b0, 32'h0);
    stray = 1'b1;
    tag = 2'h3;
    tick(7'h00, 1'b0, 32'h0, 1'b0, 32'h0);
    stray = 1'b0;
    tick(7'h00, 1'b0, 32'h0, 1'b0, 32'h0);
    tick(7'h00, 1'b0, 32'h0, 1'b0, 32'h0001_0000);
    for (int c = 0; c < 4; c++) begin
      fci = 1'b1;
      fcc = c[1:0];
      fch = 8'h00;
      fcd = 12'h008;
      tick(7'h00, 1'b1, ONES, 1'b0, 32'h0);
      fci = 1'b0;
      fcu = 1'b1;
      fcd = 12'h009;
      tick(7'h00, 1'b0, 32'h0, 1'b0, 32'h0);
      fch = 8'h02;
      tick(7'h00, 1'b0, 32'h0, 1'b0, c < 3 ? 32'h0000_2000 : 32'h0);
      fcu = 1'b0;
      tick(7'h00, 1'b0, 32'h0, 1'b0, 32'h0);
    end
    tick(7'h01, 1'b0, 32'h0, 1'b0, 32'h0);
    i_resetn = 1'b0;
    exp_s = 32'h0;
    exp_f = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    i_resetn = 1'b1;
    tick(7'h00, 1'b0, 32'h0, 1'b0, 32'h0);
    end_of_test();
  end
endmodule : tb
